// ===== rtl/scrb_register_bank.sv
// control register bank behind the command byte stream
`timescale 1ns/1ps
`default_nettype none

module scrb_register_bank
	import scrb_pkg::*;
#(
	parameter int SAMPLE_WIDTH = scrb_pkg::SAMPLE_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic link_clk,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_frame_start,
	output logic rx_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic [5:0] flag_set,
	input wire logic device_ready,
	input wire logic threshold_fault_flag,
	input wire logic [3:0] event_direction,
	input wire logic [SAMPLE_WIDTH-1:0] raw_sample,
	input wire logic [SAMPLE_WIDTH-1:0] compensated_sample,
	output logic [SAMPLE_WIDTH-1:0] sample_out,
	output logic signed [15:0] altitude_offset,
	output logic [15:0] pressure_upper_bound,
	output logic [15:0] pressure_middle_level,
	output logic [15:0] pressure_lower_bound,
	output logic [7:0] temperature_upper_bound,
	output logic [7:0] temperature_middle_level,
	output logic [7:0] temperature_lower_bound,
	output logic [5:0] interrupt_enable,
	output logic [5:0] interrupt_routing,
	output logic pressure_altitude_select,
	output logic [5:0] interrupt_flags,
	output logic compensation_on
);
	import scrb_pkg::*;

	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic wr_pending;
		logic [5:0] wr_addr;
		logic busy;
		logic req_tgl;
		scrb_req_e req_kind;
		logic [5:0] req_addr;
		logic [7:0] req_data;
		logic rsp_s1;
		logic rsp_s2;
		logic rsp_s3;
		logic [7:0] rd_data;
		logic rd_valid;
	} scrb_link_s;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic rsp_tgl;
		logic [NUM_STORED-1:0][7:0] stored;
		logic compensation;
		logic [5:0] flags;
		logic [7:0] rd_data;
		logic [SAMPLE_WIDTH-1:0] sample;
	} scrb_core_s;

	scrb_link_s lnk;
	scrb_link_s next_lnk;
	scrb_core_s core;
	scrb_core_s next_core;

	// writable bits of a stored register
	function automatic logic [7:0] scrb_write_mask(input logic [5:0] addr);
		logic [7:0] mask;
		mask = 8'h00;
		if (addr <= TEMPERATURE_LOWER_BOUND) begin
			mask = PARAM_MASK;
		end else if (addr == INTERRUPT_ENABLE) begin
			mask = ENABLE_MASK;
		end else if (addr == INTERRUPT_ROUTING_CONFIG) begin
			mask = ROUTING_MASK;
		end
		return mask;
	endfunction

	// commands that end the life of the flags
	function automatic logic scrb_is_clear_cmd(input logic [7:0] cmd);
		return cmd == CMD_READ_PT || cmd == CMD_READ_AT || cmd == CMD_READ_P
			|| cmd == CMD_READ_A || cmd == CMD_READ_T || cmd[7:5] == CMD_CONVERT;
	endfunction

	// link side: command decode and request handshake
	always_comb begin
		logic take;
		logic rsp_edge;
		next_lnk = lnk;
		take = rx_byte_valid && !lnk.busy;
		rsp_edge = lnk.rsp_s2 != lnk.rsp_s3;
		next_lnk.rst_s1 = reset;
		next_lnk.rst_s2 = lnk.rst_s1;
		next_lnk.rsp_s1 = core.rsp_tgl;
		next_lnk.rsp_s2 = lnk.rsp_s1;
		next_lnk.rsp_s3 = lnk.rsp_s2;
		next_lnk.rd_valid = 1'b0;
		if (rsp_edge) begin
			next_lnk.busy = 1'b0;
			if (lnk.req_kind == SCRB_REQ_READ) begin
				next_lnk.rd_data = core.rd_data;
				next_lnk.rd_valid = 1'b1;
			end
		end
		if (take) begin
			if (rx_frame_start) begin
				next_lnk.wr_pending = 1'b0;
				if (rx_byte[7:6] == CMD_WRITE_REG) begin
					next_lnk.wr_pending = 1'b1;
					next_lnk.wr_addr = rx_byte[5:0];
				end else if (rx_byte[7:6] == CMD_READ_REG) begin
					next_lnk.busy = 1'b1;
					next_lnk.req_tgl = !lnk.req_tgl;
					next_lnk.req_kind = SCRB_REQ_READ;
					next_lnk.req_addr = rx_byte[5:0];
				end else if (scrb_is_clear_cmd(rx_byte)) begin
					next_lnk.busy = 1'b1;
					next_lnk.req_tgl = !lnk.req_tgl;
					next_lnk.req_kind = SCRB_REQ_CLEAR;
				end
			end else if (lnk.wr_pending) begin
				next_lnk.wr_pending = 1'b0;
				next_lnk.busy = 1'b1;
				next_lnk.req_tgl = !lnk.req_tgl;
				next_lnk.req_kind = SCRB_REQ_WRITE;
				next_lnk.req_addr = lnk.wr_addr;
				next_lnk.req_data = rx_byte;
			end
		end
		if (lnk.rst_s2) begin
			next_lnk.wr_pending = 1'b0;
			next_lnk.wr_addr = 6'h00;
			next_lnk.busy = 1'b0;
			next_lnk.req_tgl = 1'b0;
			next_lnk.req_kind = SCRB_REQ_WRITE;
			next_lnk.req_addr = 6'h00;
			next_lnk.req_data = 8'h00;
			next_lnk.rsp_s2 = 1'b0;
			next_lnk.rsp_s3 = 1'b0;
			next_lnk.rd_data = 8'h00;
			next_lnk.rd_valid = 1'b0;
		end
	end

	always_ff @(posedge link_clk) begin
		lnk <= next_lnk;
	end

	// core side: register file, flags and sample path
	always_comb begin
		logic req_edge;
		logic do_clear;
		logic [5:0] gated_set;
		logic [7:0] mask;
		logic [7:0] rd;
		next_core = core;
		req_edge = core.req_s2 != core.req_s3;
		next_core.req_s1 = lnk.req_tgl;
		next_core.req_s2 = core.req_s1;
		next_core.req_s3 = core.req_s2;
		do_clear = req_edge && lnk.req_kind == SCRB_REQ_CLEAR;
		mask = scrb_write_mask(lnk.req_addr);
		if (req_edge && lnk.req_kind == SCRB_REQ_WRITE) begin
			if (lnk.req_addr < 6'(NUM_STORED)) begin
				next_core.stored[lnk.req_addr[3:0]] = lnk.req_data & mask;
			end
			if (lnk.req_addr == COMPENSATION_CONTROL) begin
				next_core.compensation = lnk.req_data[COMPENSATION_ON_BIT];
			end
		end
		// trav and window need their ready source enabled
		gated_set = flag_set & core.stored[INTERRUPT_ENABLE[3:0]][5:0]
			& {2'h3, core.stored[INTERRUPT_ENABLE[3:0]][PA_READY_BIT],
			core.stored[INTERRUPT_ENABLE[3:0]][T_READY_BIT],
			core.stored[INTERRUPT_ENABLE[3:0]][PA_READY_BIT],
			core.stored[INTERRUPT_ENABLE[3:0]][T_READY_BIT]};
		// sticky flags, a set wins over the clear
		next_core.flags = (do_clear ? 6'h00 : core.flags) | gated_set;
		rd = 8'h00;
		if (lnk.req_addr == INTERRUPT_FLAGS) begin
			rd = {threshold_fault_flag, device_ready, core.flags};
		end else if (lnk.req_addr == EVENT_DIRECTION_STATUS) begin
			rd = {4'h0, event_direction} & DIRECTION_MASK;
		end else if (lnk.req_addr == COMPENSATION_CONTROL) begin
			rd = {core.compensation, 7'h00};
		end else if (lnk.req_addr < 6'(NUM_STORED)) begin
			rd = core.stored[lnk.req_addr[3:0]];
		end
		if (req_edge) begin
			next_core.rd_data = rd;
			next_core.rsp_tgl = !core.rsp_tgl;
		end
		next_core.sample = core.compensation ? compensated_sample : raw_sample;
		if (reset) begin
			next_core.req_s2 = 1'b0;
			next_core.req_s3 = 1'b0;
			next_core.rsp_tgl = 1'b0;
			next_core.stored = {NUM_STORED{STORED_RESET}};
			next_core.compensation = COMPENSATION_RESET;
			next_core.flags = 6'h00;
			next_core.rd_data = 8'h00;
			next_core.sample = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		core <= next_core;
	end

	assign rx_ready = !lnk.busy;
	assign rd_data = lnk.rd_data;
	assign rd_valid = lnk.rd_valid;
	assign sample_out = core.sample;
	// high byte on top, signed centimetres
	assign altitude_offset = signed'({core.stored[ALTITUDE_OFFSET_HIGH[3:0]],
		core.stored[ALTITUDE_OFFSET_LOW[3:0]]});
	assign pressure_upper_bound = {core.stored[PRESSURE_UPPER_BOUND_HIGH[3:0]],
		core.stored[PRESSURE_UPPER_BOUND_LOW[3:0]]};
	assign pressure_middle_level = {core.stored[PRESSURE_MIDDLE_LEVEL_HIGH[3:0]],
		core.stored[PRESSURE_MIDDLE_LEVEL_LOW[3:0]]};
	assign pressure_lower_bound = {core.stored[PRESSURE_LOWER_BOUND_HIGH[3:0]],
		core.stored[PRESSURE_LOWER_BOUND_LOW[3:0]]};
	assign temperature_upper_bound = core.stored[TEMPERATURE_UPPER_BOUND[3:0]];
	assign temperature_middle_level = core.stored[TEMPERATURE_MIDDLE_LEVEL[3:0]];
	assign temperature_lower_bound = core.stored[TEMPERATURE_LOWER_BOUND[3:0]];
	assign interrupt_enable = core.stored[INTERRUPT_ENABLE[3:0]][5:0];
	assign interrupt_routing = core.stored[INTERRUPT_ROUTING_CONFIG[3:0]][5:0];
	assign pressure_altitude_select =
		core.stored[INTERRUPT_ROUTING_CONFIG[3:0]][PRESSURE_ALTITUDE_SELECT_BIT];
	assign interrupt_flags = core.flags;
	assign compensation_on = core.compensation;
endmodule

`default_nettype wire

// ===== common/scrb_pkg.sv
// constants and types of the sensor control register bank
package scrb_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 20;
	localparam int NUM_SRC = 6;

	// register offsets
	localparam logic [5:0] ALTITUDE_OFFSET_LOW = 6'h00;
	localparam logic [5:0] ALTITUDE_OFFSET_HIGH = 6'h01;
	localparam logic [5:0] PRESSURE_UPPER_BOUND_LOW = 6'h02;
	localparam logic [5:0] PRESSURE_UPPER_BOUND_HIGH = 6'h03;
	localparam logic [5:0] PRESSURE_MIDDLE_LEVEL_LOW = 6'h04;
	localparam logic [5:0] PRESSURE_MIDDLE_LEVEL_HIGH = 6'h05;
	localparam logic [5:0] PRESSURE_LOWER_BOUND_LOW = 6'h06;
	localparam logic [5:0] PRESSURE_LOWER_BOUND_HIGH = 6'h07;
	localparam logic [5:0] TEMPERATURE_UPPER_BOUND = 6'h08;
	localparam logic [5:0] TEMPERATURE_MIDDLE_LEVEL = 6'h09;
	localparam logic [5:0] TEMPERATURE_LOWER_BOUND = 6'h0a;
	localparam logic [5:0] INTERRUPT_ENABLE = 6'h0b;
	localparam logic [5:0] INTERRUPT_ROUTING_CONFIG = 6'h0c;
	localparam logic [5:0] INTERRUPT_FLAGS = 6'h0d;
	localparam logic [5:0] EVENT_DIRECTION_STATUS = 6'h0e;
	localparam logic [5:0] COMPENSATION_CONTROL = 6'h0f;
	localparam int NUM_STORED = 13;

	// reset values
	localparam logic [7:0] STORED_RESET = 8'h00;
	localparam logic COMPENSATION_RESET = 1'h1;

	// writable bits, and the read mask of the direction status
	localparam logic [7:0] PARAM_MASK = 8'hff;
	localparam logic [7:0] ENABLE_MASK = 8'h3f;
	localparam logic [7:0] ROUTING_MASK = 8'h7f;
	localparam logic [7:0] DIRECTION_MASK = 8'h0f;

	// field positions
	localparam int PRESSURE_ALTITUDE_SELECT_BIT = 6;
	localparam int THRESHOLD_FAULT_BIT = 7;
	localparam int DEVICE_READY_BIT = 6;
	localparam int COMPENSATION_ON_BIT = 7;
	localparam int PA_READY_BIT = 5;
	localparam int T_READY_BIT = 4;

	// command bytes
	localparam logic [1:0] CMD_READ_REG = 2'h2;
	localparam logic [1:0] CMD_WRITE_REG = 2'h3;
	localparam logic [2:0] CMD_CONVERT = 3'h2;
	localparam logic [7:0] CMD_READ_PT = 8'h10;
	localparam logic [7:0] CMD_READ_AT = 8'h11;
	localparam logic [7:0] CMD_READ_P = 8'h30;
	localparam logic [7:0] CMD_READ_A = 8'h31;
	localparam logic [7:0] CMD_READ_T = 8'h32;

	typedef enum logic [1:0] {SCRB_REQ_WRITE, SCRB_REQ_READ, SCRB_REQ_CLEAR} scrb_req_e;
endpackage

// ===== bench/scrb_register_bank_sva.sv
// assertion checker for the register bank ports
`timescale 1ns/1ps
`default_nettype none
module scrb_register_bank_sva
	import scrb_pkg::*;
#(
	parameter int SAMPLE_WIDTH = 20
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic link_clk,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_frame_start,
	input wire logic rx_ready,
	input wire logic rd_valid,
	input wire logic [5:0] flag_set,
	input wire logic [SAMPLE_WIDTH-1:0] raw_sample,
	input wire logic [SAMPLE_WIDTH-1:0] compensated_sample,
	input wire logic [SAMPLE_WIDTH-1:0] sample_out,
	input wire logic signed [15:0] altitude_offset,
	input wire logic [5:0] interrupt_enable,
	input wire logic pressure_altitude_select,
	input wire logic [5:0] interrupt_flags,
	input wire logic compensation_on
);
	logic [5:0] quiet;
	// cycles since the last link byte, saturating
	always_ff @(posedge ref_clk) begin
		quiet <= (reset || rx_byte_valid) ? 6'h00 : ((quiet == 6'h3f) ? quiet : quiet + 6'h01);
	end
	sequence read_taken;
		rx_byte_valid && rx_ready && rx_frame_start && rx_byte[7:6] == CMD_READ_REG;
	endsequence
	sequence answer_due;
		##[2:12] rd_valid;
	endsequence
	a_sample_path: assert property (@(posedge ref_clk) disable iff (reset)
		!$past(reset) |-> sample_out == ($past(compensation_on) ?
		$past(compensated_sample) : $past(raw_sample)))
		else $error("sample_out does not follow compensation_on");
	a_flag_cause: assert property (@(posedge ref_clk) disable iff (reset)
		(interrupt_flags & ~$past(interrupt_flags) & ~($past(flag_set) & $past(interrupt_enable)))
		== 6'h00) else $error("flag rose without enabled set pulse");
	a_ready_gate: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(interrupt_flags[3]) || $rose(interrupt_flags[1]) |-> $past(interrupt_enable[5]))
		else $error("pressure event flag without ready enable");
	a_flag_hold: assert property (@(posedge ref_clk) disable iff (reset)
		quiet == 6'h3f |-> (~interrupt_flags & $past(interrupt_flags)) == 6'h00)
		else $error("flag fell without a command");
	a_config_hold: assert property (@(posedge ref_clk) disable iff (reset)
		quiet == 6'h3f |-> $stable(interrupt_enable) && $stable(pressure_altitude_select))
		else $error("interrupt config changed without a write");
	a_offset_hold: assert property (@(posedge ref_clk) disable iff (reset)
		quiet == 6'h3f |-> $stable(altitude_offset)) else $error("offset changed without a write");
	a_read_answer: assert property (@(posedge link_clk) disable iff (reset)
		read_taken |-> answer_due) else $error("read not answered in time");
	a_read_busy: assert property (@(posedge link_clk) disable iff (reset)
		read_taken |=> !rx_ready) else $error("rx_ready stayed high after a read");
	a_valid_pulse: assert property (@(posedge link_clk) disable iff (reset)
		rd_valid |=> !rd_valid) else $error("rd_valid longer than one cycle");
endmodule
bind scrb_register_bank scrb_register_bank_sva #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) sva_i (
	.ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .rx_byte_valid(rx_byte_valid),
	.rx_byte(rx_byte), .rx_frame_start(rx_frame_start), .rx_ready(rx_ready),
	.rd_valid(rd_valid), .flag_set(flag_set), .raw_sample(raw_sample),
	.compensated_sample(compensated_sample), .sample_out(sample_out),
	.altitude_offset(altitude_offset), .interrupt_enable(interrupt_enable),
	.pressure_altitude_select(pressure_altitude_select), .interrupt_flags(interrupt_flags),
	.compensation_on(compensation_on));
`default_nettype wire

// ===== bench/scrb_host_model.sv
// host model sending command bytes over the link
`timescale 1ns/1ps
`default_nettype none
module scrb_host_model (
	input wire logic link_clk,
	input wire logic rx_ready,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic rx_frame_start
);
	import scrb_pkg::*;
	initial begin
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_frame_start = 1'b0;
	end
	// byte held for one link cycle once rx_ready is seen high, then the data line shows the inverse
	task automatic send(input logic start, input logic [7:0] b);
		@(negedge link_clk);
		while (rx_ready !== 1'b1) @(negedge link_clk);
		@(posedge link_clk);
		rx_byte_valid <= 1'b1;
		rx_byte <= b;
		rx_frame_start <= start;
		@(posedge link_clk);
		rx_byte_valid <= 1'b0;
		rx_byte <= ~b;
		rx_frame_start <= 1'b0;
	endtask
	task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
		send(1'b1, {CMD_WRITE_REG, a});
		send(1'b0, d);
	endtask
	task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
		d = 8'hxx;
		send(1'b1, {CMD_READ_REG, a});
		repeat (14) begin
			@(negedge link_clk);
			if (rd_valid === 1'b1) d = rd_data;
		end
	endtask
endmodule
`default_nettype wire

// ===== bench/scrb_register_bank_tb.sv
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module scrb_register_bank_tb;
	import scrb_pkg::*;
	logic ref_clk = 0, link_clk = 0, reset = 1, device_ready = 0, fault = 0;
	logic rx_byte_valid, rx_frame_start, rx_ready, rd_valid, pas, comp_on;
	logic [7:0] rx_byte, rd_data, d, tub, tml, tlb;
	logic [5:0] flag_set = 6'h00, interrupt_enable, interrupt_routing, interrupt_flags;
	logic [3:0] dir = 4'h0;
	logic [19:0] raw = 20'h12345, comp = 20'habcde, sample_out;
	logic signed [15:0] altitude_offset;
	logic [15:0] pub, pml, plb;
	logic [7:0] cmds [6] = '{CMD_READ_PT, CMD_READ_AT, CMD_READ_P, CMD_READ_A, CMD_READ_T,
		{CMD_CONVERT, 5'h0a}};
	int n_mismatch = 0, n_compared = 0;
	always #4 ref_clk = ~ref_clk;
	initial #3 forever #16 link_clk = ~link_clk;
	scrb_register_bank #(.SAMPLE_WIDTH(20)) scrb_register_bank_i (.ref_clk(ref_clk),
		.reset(reset), .link_clk(link_clk), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
		.rx_frame_start(rx_frame_start), .rx_ready(rx_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .flag_set(flag_set), .device_ready(device_ready),
		.threshold_fault_flag(fault), .event_direction(dir), .raw_sample(raw),
		.compensated_sample(comp), .sample_out(sample_out), .altitude_offset(altitude_offset),
		.pressure_upper_bound(pub), .pressure_middle_level(pml), .pressure_lower_bound(plb),
		.temperature_upper_bound(tub), .temperature_middle_level(tml),
		.temperature_lower_bound(tlb), .interrupt_enable(interrupt_enable),
		.interrupt_routing(interrupt_routing), .pressure_altitude_select(pas),
		.interrupt_flags(interrupt_flags), .compensation_on(comp_on));
	scrb_host_model scrb_host_model_i (.link_clk(link_clk), .rx_ready(rx_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_frame_start(rx_frame_start));
	task check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task rd_chk(input logic [5:0] a, input logic [7:0] e);
		scrb_host_model_i.reg_read(a, d);
		check("read_reg", d, e);
	endtask
	initial begin
		repeat (30000) @(posedge ref_clk);
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (40) @(posedge ref_clk);
		for (int a = 0; a < 17; a++) rd_chk(a == 16 ? 6'h3f : 6'(a), a == 15 ? 8'h80 : 8'h00);
		for (int a = 0; a < 16; a++) scrb_host_model_i.reg_write(6'(a), {4'(a), ~4'(a)});
		for (int a = 0; a < 16; a++) rd_chk(6'(a), a > 12 ? (a == 15 ? 8'h80 : 8'h00) :
			{4'(a), ~4'(a)} & (a == 11 ? 8'h3f : (a == 12 ? 8'h7f : 8'hff)));
		check("alt", {4'h0, altitude_offset}, 20'h01e0f);
		check("pub", pub, 16'h3c2d);
		check("pml", pml, 16'h5a4b);
		check("plb", plb, 16'h7869);
		check("temps", {tub, tml}, 16'h8796);
		check("tlb", tlb, 8'ha5);
		check("int_cfg", {pas, interrupt_routing, interrupt_enable}, {7'h43, 6'h34});
		scrb_host_model_i.reg_write(ALTITUDE_OFFSET_HIGH, 8'hd8);
		scrb_host_model_i.reg_write(ALTITUDE_OFFSET_LOW, 8'heb);
		repeat (10) @(posedge ref_clk);
		check("alt_neg", {4'h0, altitude_offset}, 20'h0d8eb);
		check("alt_sign", altitude_offset < 0, 1'b1);
		for (int i = 0; i < 2; i++) begin
			scrb_host_model_i.reg_write(COMPENSATION_CONTROL, {i[0], 7'h00});
			repeat (10) @(posedge ref_clk);
			check("sample", sample_out, i[0] ? comp : raw);
			check("comp_on", comp_on, i[0]);
		end
		@(posedge ref_clk) {device_ready, fault, dir} <= 6'h3a;
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk) flag_set <= 6'h3f;
			@(posedge ref_clk) flag_set <= 6'h00;
			repeat (2) @(posedge ref_clk);
			check("flags_set", interrupt_flags, 6'h34);
			scrb_host_model_i.reg_write(INTERRUPT_FLAGS, 8'h00);
			rd_chk(INTERRUPT_FLAGS, 8'hf4);
			rd_chk(EVENT_DIRECTION_STATUS, 8'h0a);
			scrb_host_model_i.send(1'b1, cmds[i]);
			repeat (20) @(posedge ref_clk);
			check("flags_clear", interrupt_flags, 6'h00);
		end
		stop_test();
	end
endmodule
`default_nettype wire
